// >>> logic/frs_pkg.sv
// Package: constants and carriers for the result status and host port block
package frs_pkg;
  // ****************************************
  // Bit positions
  // ****************************************
  localparam int BIT0 = 0;
  localparam int BIT1 = 1;
  localparam int BIT2 = 2;
  localparam int BIT3 = 3;
  localparam int BIT4 = 4;
  localparam int BIT5 = 5;
  localparam int BIT6 = 6;
  localparam int BIT7 = 7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BAD_TRACK_CODE = 8'hFF;
  localparam logic SEL_STATUS = 1'b0;
  localparam logic SEL_DATA = 1'b1;

  // ****************************************
  // Carriers
  // ****************************************
  // One-cycle event strobes from the command engine
  typedef struct packed {
    logic cmd_start;
    logic end_of_cyl;
    logic id_crc_err;
    logic data_crc_err;
    logic overrun;
    logic sector_missing;
    logic id_read_fail;
    logic track_start_missing;
    logic write_attempt;
    logic id_sync_absent;
    logic payload_sync_absent;
    logic deleted_seen;
    logic track_compare;
    logic compare_equal;
    logic compare_miss;
  } frs_evt_s;

  // Drive-side pin levels, asynchronous and passed through the two-flop synchroniser in the port
  typedef struct packed {
    logic write_protect;
    logic track_zero;
    logic head_side_state;
    logic unit_pick_hi;
    logic unit_pick_lo;
  } frs_drv_s;

  typedef enum logic [1:0] {
    FRS_IDLE = 2'b00,
    FRS_RD = 2'b01,
    FRS_WR = 2'b10
  } frs_acc_e;
endpackage

// >>> logic/frs_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module frs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// >>> logic/frs_strobe.sv
// Host strobe decoder: turns synchronised strobe levels into access pulses
`timescale 1ns/10ps
module frs_strobe (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Synchronised host levels
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // Access pulses
  output logic o_rd_start,
  output logic o_rd_end,
  output logic o_wr_start
);
  import frs_pkg::*;

  frs_acc_e acc_reg;
  frs_acc_e acc_next;

  // ****************************************
  // Access state
  // ****************************************
  // Both strobes low is illegal and treated as no access
  always_comb begin
    acc_next = FRS_IDLE;
    case ({i_rd_n, i_wr_n})
      2'b01: acc_next = FRS_RD;
      2'b10: acc_next = FRS_WR;
      default: acc_next = FRS_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      acc_reg <= FRS_IDLE;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign o_rd_start = (acc_next == FRS_RD) && (acc_reg != FRS_RD);
  assign o_rd_end = (acc_reg == FRS_RD) && (acc_next != FRS_RD);
  assign o_wr_start = (acc_next == FRS_WR) && (acc_reg != FRS_WR);
endmodule

// >>> logic/frs_port.sv
// Result status registers one to three and the host status/data port
`timescale 1ns/10ps
module frs_port (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Host bus pins
  input wire logic i_reg_select_line,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_db,
  output logic [7:0] o_db,
  output logic o_db_oe,
  // Command engine side
  input wire frs_pkg::frs_evt_s i_evt,
  input wire logic [7:0] i_cyl_medium,
  input wire logic [7:0] i_target_id_store,
  input wire logic i_host_transfer_request,
  input wire logic i_transfer_direction,
  input wire logic [5:0] i_msr_low,
  input wire logic i_rsp_load,
  input wire logic [7:0] i_rsp_byte,
  output logic [7:0] o_cmd_byte,
  output logic o_cmd_valid,
  output logic o_rsp_taken,
  // Drive side pins
  input wire frs_pkg::frs_drv_s i_drv,
  // Result registers
  output logic [7:0] o_result_status_one,
  output logic [7:0] o_result_status_two,
  output logic [7:0] o_result_status_three
);
  import frs_pkg::*;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [2:0] host_sync;
  logic [7:0] db_sync;
  frs_drv_s drv_sync;
  logic sel_s;
  logic rd_n_s;
  logic wr_n_s;
  logic rd_start;
  logic rd_end;
  logic wr_start;

  frs_sync #(.W(3)) u_host_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async({i_reg_select_line, i_rd_n, i_wr_n}),
    .o_sync(host_sync)
  );

  // Bus byte must settle before the strobe, so two flops keep pace with it
  frs_sync #(.W(8)) u_db_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_db),
    .o_sync(db_sync)
  );

  frs_sync #(.W($bits(frs_drv_s))) u_drv_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_drv),
    .o_sync(drv_sync)
  );

  // Strobes reset low, which decodes as both low and so as no access
  assign sel_s = host_sync[2];
  assign rd_n_s = host_sync[1];
  assign wr_n_s = host_sync[0];

  // ****************************************
  // Strobe decode
  // ****************************************

  frs_strobe u_strobe (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_rd_n(rd_n_s),
    .i_wr_n(wr_n_s),
    .o_rd_start(rd_start),
    .o_rd_end(rd_end),
    .o_wr_start(wr_start)
  );

  // ****************************************
  // Register one flags
  // ****************************************
  logic [7:0] rs1_reg;
  logic [7:0] rs1_next;
  logic [7:0] rs1_set;
  logic write_blocked;

  // Protect level lags its pin by two cycles through the synchroniser
  assign write_blocked = i_evt.write_attempt && drv_sync.write_protect;

  always_comb begin
    rs1_set = BYTE_ZERO;
    rs1_set[BIT7] = i_evt.end_of_cyl;
    rs1_set[BIT5] = i_evt.id_crc_err || i_evt.data_crc_err;
    rs1_set[BIT4] = i_evt.overrun;
    rs1_set[BIT2] = i_evt.sector_missing || i_evt.id_read_fail
      || i_evt.track_start_missing;
    rs1_set[BIT1] = write_blocked;
    rs1_set[BIT0] = i_evt.id_sync_absent || i_evt.payload_sync_absent;
  end

  // Set beats the start-of-command clear so no event is lost
  always_comb begin
    rs1_next = (i_evt.cmd_start ? BYTE_ZERO : rs1_reg) | rs1_set;
    rs1_next[BIT6] = 1'b0;
    rs1_next[BIT3] = 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rs1_reg <= BYTE_ZERO;
    end else begin
      rs1_reg <= rs1_next;
    end
  end

  // ****************************************
  // Register two flags
  // ****************************************
  logic [7:0] rs2_reg;
  logic [7:0] rs2_next;
  logic [7:0] rs2_set;
  logic cyl_diff;

  // Cylinders are compared only in the cycle the engine flags
  assign cyl_diff = i_evt.track_compare && (i_cyl_medium != i_target_id_store);

  always_comb begin
    rs2_set = BYTE_ZERO;
    rs2_set[BIT6] = i_evt.deleted_seen;
    rs2_set[BIT5] = i_evt.data_crc_err;
    rs2_set[BIT4] = cyl_diff && i_evt.sector_missing;
    rs2_set[BIT3] = i_evt.compare_equal;
    rs2_set[BIT2] = i_evt.compare_miss;
    rs2_set[BIT1] = cyl_diff && i_evt.sector_missing
      && (i_cyl_medium == BAD_TRACK_CODE);
    rs2_set[BIT0] = i_evt.payload_sync_absent;
  end

  always_comb begin
    rs2_next = (i_evt.cmd_start ? BYTE_ZERO : rs2_reg) | rs2_set;
    rs2_next[BIT7] = 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rs2_reg <= BYTE_ZERO;
    end else begin
      rs2_reg <= rs2_next;
    end
  end

  // ****************************************
  // Register three drive state
  // ****************************************
  logic [7:0] rs3_reg;
  logic [7:0] rs3_next;

  always_comb begin
    rs3_next = BYTE_ZERO;
    rs3_next[BIT7] = 1'b0;
    rs3_next[BIT6] = drv_sync.write_protect;
    rs3_next[BIT5] = 1'b1;
    rs3_next[BIT4] = drv_sync.track_zero;
    rs3_next[BIT3] = drv_sync.write_protect;
    rs3_next[BIT2] = drv_sync.head_side_state;
    rs3_next[BIT1] = drv_sync.unit_pick_hi;
    rs3_next[BIT0] = drv_sync.unit_pick_lo;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rs3_reg <= BYTE_ZERO;
    end else begin
      rs3_reg <= rs3_next;
    end
  end

  assign o_result_status_one = rs1_reg;
  assign o_result_status_two = rs2_reg;
  assign o_result_status_three = rs3_reg;

  // ****************************************
  // Command and result data register
  // ****************************************
  logic [7:0] data_reg;
  logic cmd_valid_reg;
  logic rsp_taken_reg;
  logic host_write;
  logic rd_sel_reg;

  // Writes with select low are illegal and dropped
  assign host_write = wr_start && (sel_s == SEL_DATA);

  // Host write has priority over an engine load in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      data_reg <= BYTE_ZERO;
    end else if (host_write) begin
      data_reg <= db_sync;
    end else if (i_rsp_load) begin
      data_reg <= i_rsp_byte;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= host_write;
    end
  end

  // Select kept from read start, as the host may drop it with the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rd_sel_reg <= SEL_STATUS;
    end else if (rd_start) begin
      rd_sel_reg <= sel_s;
    end
  end

  // Pulse marks a result byte consumed, so the engine may load the next
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rsp_taken_reg <= 1'b0;
    end else begin
      rsp_taken_reg <= rd_end && (rd_sel_reg == SEL_DATA);
    end
  end

  assign o_cmd_byte = data_reg;
  assign o_cmd_valid = cmd_valid_reg;
  assign o_rsp_taken = rsp_taken_reg;

  // ****************************************
  // Host read path
  // ****************************************
  logic [7:0] msr;
  logic [7:0] db_out_reg;
  logic db_oe_reg;

  always_comb begin
    msr = {2'b00, i_msr_low};
    msr[BIT7] = i_host_transfer_request;
    msr[BIT6] = i_transfer_direction;
  end

  // Byte is captured at strobe start and held for the whole read
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      db_out_reg <= BYTE_ZERO;
    end else if (rd_start) begin
      db_out_reg <= (sel_s == SEL_STATUS) ? msr : data_reg;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      db_oe_reg <= 1'b0;
    end else if (rd_start) begin
      db_oe_reg <= 1'b1;
    end else if (rd_end) begin
      db_oe_reg <= 1'b0;
    end
  end

  assign o_db = db_out_reg;
  assign o_db_oe = db_oe_reg;
endmodule

// >>> verif/frs_port_checker.sv
// Checker of the result status registers and the host port
`timescale 1ns/10ps
module frs_port_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Host side
  input wire logic i_reg_select_line,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] o_db,
  input wire logic o_db_oe,
  input wire logic o_cmd_valid,
  // Engine side
  input wire frs_pkg::frs_evt_s i_evt,
  input wire logic [7:0] i_cyl_medium,
  input wire logic [7:0] i_target_id_store,
  input wire logic i_host_transfer_request,
  input wire logic i_transfer_direction,
  input wire logic [5:0] i_msr_low,
  // Results
  input wire logic [7:0] o_result_status_one,
  input wire logic [7:0] o_result_status_two,
  input wire logic [7:0] o_result_status_three
);
  import frs_pkg::*;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  property p_eoc; i_evt.end_of_cyl |=> o_result_status_one[BIT7]; endproperty
  a_eoc: assert property (p_eoc) else $error("end of cylinder flag missing");
  property p_zero;
    (o_result_status_one[BIT6] | o_result_status_one[BIT3] | o_result_status_two[BIT7]
      | o_result_status_three[BIT7]) == 1'b0;
  endproperty
  a_zero: assert property (p_zero) else $error("unused bit set");
  property p_nd;
    (i_evt.sector_missing | i_evt.id_read_fail | i_evt.track_start_missing)
      |=> o_result_status_one[BIT2];
  endproperty
  a_nd: assert property (p_nd) else $error("sector missing flag absent");
  property p_md;
    i_evt.payload_sync_absent |=> o_result_status_one[BIT0] && o_result_status_two[BIT0];
  endproperty
  a_md: assert property (p_md) else $error("sync absent flags not paired");
  property p_clr;
    i_evt.cmd_start && i_evt[13:0] == 14'h0000
      |=> {o_result_status_one, o_result_status_two} == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_hold;
    !i_evt.cmd_start |=> (o_result_status_two & $past(o_result_status_two))
      == $past(o_result_status_two) && (o_result_status_one & $past(o_result_status_one))
      == $past(o_result_status_one);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without new command");
  property p_wc;
    i_evt.track_compare && i_evt.sector_missing && i_cyl_medium != i_target_id_store
      |=> o_result_status_two[BIT4]
      && ($past(i_cyl_medium) != BAD_TRACK_CODE || o_result_status_two[BIT1]);
  endproperty
  a_wc: assert property (p_wc) else $error("cylinder mismatch flags wrong");
  property p_msr;
    $fell(i_rd_n) && i_wr_n && i_reg_select_line == SEL_STATUS |-> ##[2:5] o_db_oe
      && o_db == {i_host_transfer_request, i_transfer_direction, i_msr_low};
  endproperty
  a_msr: assert property (p_msr) else $error("main status read wrong");
  property p_wr;
    $fell(i_wr_n) && i_rd_n && i_reg_select_line == SEL_DATA |-> ##[2:6] o_cmd_valid;
  endproperty
  a_wr: assert property (p_wr) else $error("data write not stored");
  property p_wr0;
    $fell(i_wr_n) && i_reg_select_line == SEL_STATUS |-> ##1 (!o_cmd_valid) [*8];
  endproperty
  a_wr0: assert property (p_wr0) else $error("status write accepted");
  c_clr: cover property (i_evt.cmd_start);
  c_msr: cover property (o_db_oe && !i_reg_select_line);
  c_wr: cover property (o_cmd_valid);
endmodule
bind frs_port frs_port_checker i_chk (
  .i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst),
  .i_reg_select_line(i_reg_select_line),
  .i_rd_n(i_rd_n),
  .i_wr_n(i_wr_n),
  .o_db(o_db),
  .o_db_oe(o_db_oe),
  .o_cmd_valid(o_cmd_valid),
  .i_evt(i_evt),
  .i_cyl_medium(i_cyl_medium),
  .i_target_id_store(i_target_id_store),
  .i_host_transfer_request(i_host_transfer_request),
  .i_transfer_direction(i_transfer_direction),
  .i_msr_low(i_msr_low),
  .o_result_status_one(o_result_status_one),
  .o_result_status_two(o_result_status_two),
  .o_result_status_three(o_result_status_three)
);

// >>> verif/frs_host.sv
// Host processor model on the parallel port
`timescale 1ns/10ps
module frs_host (
  // Clock
  input wire logic i_ref_clk,
  // Host pins
  output logic o_sel,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_db,
  input wire logic [7:0] i_db,
  input wire logic i_db_oe
);
  initial begin
    o_sel = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_db = 8'hA5;
  end
  // ****
  // Accesses, one strobe low at a time
  // ****
  task automatic rd(input logic sel, output logic [7:0] d, output logic to);
    to = 1'b1;
    d = 8'h00;
    @(negedge i_ref_clk);
    o_sel = sel;
    o_rd_n = 1'b0;
    for (int i = 0; i < 12 && to; i++) begin
      @(posedge i_ref_clk);
      if (i_db_oe === 1'b1) begin
        d = i_db;
        to = 1'b0;
      end
    end
    @(negedge i_ref_clk);
    o_rd_n = 1'b1;
    repeat (4) @(negedge i_ref_clk);
  endtask
  // Data held past the strobe rise: the byte is synchronised like the strobe
  task automatic wr(input logic sel, input logic [7:0] b);
    @(negedge i_ref_clk);
    o_sel = sel;
    o_db = b;
    o_wr_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    o_wr_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    o_db = ~b;
    repeat (2) @(negedge i_ref_clk);
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the result status registers and host port
`timescale 1ns/10ps
module tb_top;
  import frs_pkg::*;
  logic i_ref_clk, i_nrst, sel, rd_n, wr_n, db_oe, rsp_load, host_transfer_request, transfer_direction, to, rsp_taken;
  logic [7:0] db_in, db_out, cyl, tgt, cmd_byte, rsp_byte, r1, r2, r3, d;
  logic [5:0] msr_low;
  logic [15:0] lfsr, fl;
  frs_evt_s evt;
  frs_drv_s drv;
  int num_errors, num_checks, num_taken;
  frs_port i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_reg_select_line(sel),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_db(db_in), .o_db(db_out), .o_db_oe(db_oe),
    .i_evt(evt), .i_cyl_medium(cyl), .i_target_id_store(tgt),
    .i_host_transfer_request(host_transfer_request), .i_transfer_direction(transfer_direction), .i_msr_low(msr_low),
    .i_rsp_load(rsp_load), .i_rsp_byte(rsp_byte), .o_cmd_byte(cmd_byte),
    .o_cmd_valid(), .o_rsp_taken(rsp_taken), .i_drv(drv), .o_result_status_one(r1),
    .o_result_status_two(r2), .o_result_status_three(r3));
  frs_host i_host (.i_ref_clk(i_ref_clk), .o_sel(sel), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_db(db_in), .i_db(db_out), .i_db_oe(db_oe));
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Set wins over the clear of a new command
  function automatic logic [15:0] next_flags(input logic [15:0] f, input frs_evt_s v,
    input logic [7:0] c, input logic [7:0] t, input logic wp);
    logic bad;
    logic [7:0] a, b;
    bad = v.track_compare & v.sector_missing & (c != t);
    a = {v.end_of_cyl, 1'b0, v.id_crc_err | v.data_crc_err, v.overrun, 1'b0,
      v.sector_missing | v.id_read_fail | v.track_start_missing, v.write_attempt & wp,
      v.id_sync_absent | v.payload_sync_absent};
    b = {1'b0, v.deleted_seen, v.data_crc_err, bad, v.compare_equal, v.compare_miss,
      bad & (c == BAD_TRACK_CODE), v.payload_sync_absent};
    return (v.cmd_start ? 16'h0000 : f) | {a, b};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hrd(input logic s);
    i_host.rd(s, d, to);
    if (to !== 1'b0) begin
      num_errors++;
      conclude;
    end
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Counts consumed result bytes, sampled away from the launching edge
  always @(negedge i_ref_clk) begin
    if (rsp_taken === 1'b1) num_taken <= num_taken + 1;
  end
  // ****
  // Sequence
  // ****
  initial begin
    {i_nrst, rsp_load, host_transfer_request, transfer_direction, msr_low, cyl, tgt, rsp_byte, fl} = '0;
    evt = '0;
    drv = '0;
    lfsr = 16'hD082;
    repeat (12) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    for (int w = 0; w < 2; w++) begin
      drv.write_protect = w[0];
      repeat (4) @(negedge i_ref_clk);
      for (int i = 0; i < 24; i++) begin
        lfsr = lfsr_next(lfsr);
        evt = frs_evt_s'({lfsr[0] & lfsr[15], lfsr[14:1]});
        cyl = (i % 3 == 1) ? BAD_TRACK_CODE : lfsr[7:0];
        tgt = lfsr[15:8];
        if (i < 2) evt = '0;
        if (i == 0) evt.cmd_start = 1'b1;
        if (i == 1) {evt.sector_missing, evt.track_compare, tgt} = {2'b11, 8'h00};
        fl = next_flags(fl, evt, cyl, tgt, w[0]);
        @(negedge i_ref_clk);
        evt = '0;
        @(negedge i_ref_clk);
        chk({r1, r2}, fl);
      end
    end
    $display("event flags done");
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      drv = frs_drv_s'(lfsr[4:0]);
      repeat (5) @(negedge i_ref_clk);
      chk({8'h00, r3}, {9'h000, drv.write_protect, 1'b1, drv.track_zero, drv.write_protect,
        drv.head_side_state, drv.unit_pick_hi, drv.unit_pick_lo});
    end
    $display("drive status done");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      {host_transfer_request, transfer_direction, msr_low} = lfsr[7:0];
      hrd(SEL_STATUS);
      chk({8'h00, d}, {8'h00, lfsr[7:0]});
      i_host.wr(SEL_DATA, lfsr[15:8]);
      chk({8'h00, cmd_byte}, {8'h00, lfsr[15:8]});
      i_host.wr(SEL_STATUS, ~lfsr[15:8]);
      chk({8'h00, cmd_byte}, {8'h00, lfsr[15:8]});
      @(negedge i_ref_clk);
      rsp_byte = lfsr[11:4];
      rsp_load = 1'b1;
      @(negedge i_ref_clk);
      rsp_load = 1'b0;
      hrd(SEL_DATA);
      chk({8'h00, d}, {8'h00, lfsr[11:4]});
      chk(16'(num_taken), 16'(i + 1));
    end
    $display("host port done");
    conclude;
  end
endmodule
